// ### core/etp_pkg.sv
package etp_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ETP_CTRL_OFS = 12'h000;
  localparam logic [11:0] ETP_STAT_OFS = 12'h004;
  localparam logic [11:0] ETP_FRMS_OFS = 12'h008;
  localparam int ETP_CTRL_TSEL_LSB = 0;
  localparam int ETP_CTRL_SLAVE_BIT = 2;
  localparam int ETP_STAT_NIB_BIT = 13;
  localparam int ETP_STAT_LOOP_BIT = 14;
  localparam logic [1:0] ETP_TSEL_RST = 2'h0;
  localparam logic ETP_SLAVE_RST = 1'b0;
  // ----------------------------------------------------------------
  // timing references and frame shape
  // ----------------------------------------------------------------
  localparam logic [1:0] ETP_TSEL_LOOP = 2'h0;
  localparam int ETP_FRAME_BITS = 4296;
  localparam int ETP_OH_BITS = 56;
  localparam int ETP_CNT_W = 13;
  localparam int ETP_SYNC_STAGES = 2;
  localparam int ETP_PIN_W = 9;
  localparam logic [ETP_CNT_W-1:0] ETP_CNT_RST = 13'h0000;
  localparam logic [1:0] ETP_PHASE_RST = 2'h0;
  localparam logic [15:0] ETP_FRMS_RST = 16'h0000;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic nibble;
    logic [3:0] data;
  } etp_payload_s;
  typedef struct packed {
    logic frame_ref;
    logic local_clk;
    logic line_clk;
    logic nib_sel;
    logic serial;
    logic [3:0] nibble;
  } etp_pins_s;
endpackage

// ### core/etp_tx_payload_in.sv
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
module etp_tx_payload_in #(
  parameter int FRAME_BITS = etp_pkg::ETP_FRAME_BITS,
  parameter int OH_BITS = etp_pkg::ETP_OH_BITS
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_serial_payload_in,
  input wire logic [3:0] tx_nibble_payload_in,
  input wire logic nibble_interface_select,
  input wire logic tx_local_ref_clock,
  input wire logic line_recovered_clock,
  input wire logic tx_frame_reference_in,
  output logic tx_nibble_sample_clock,
  output logic tx_overhead_warning,
  output logic tx_end_of_frame_pulse,
  output logic loop_timed_clock_out,
  output etp_pkg::etp_payload_s payload_out
);
  localparam int CW = etp_pkg::ETP_CNT_W;
  localparam logic [CW-1:0] LAST = CW'(FRAME_BITS - 1);
  localparam logic [CW-1:0] OHN = CW'(OH_BITS);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // both reference clocks are oversampled by clk_sys, so an edge
  // is only seen when clk_sys runs well above the bit rate
  etp_pkg::etp_pins_s pins_raw;
  etp_pkg::etp_pins_s pins_s;
  logic [etp_pkg::ETP_PIN_W-1:0] meta_r;
  logic [etp_pkg::ETP_PIN_W-1:0] sync_r;
  assign pins_raw = '{frame_ref: tx_frame_reference_in,
                      local_clk: tx_local_ref_clock,
                      line_clk: line_recovered_clock,
                      nib_sel: nibble_interface_select,
                      serial: tx_serial_payload_in,
                      nibble: tx_nibble_payload_in};
  genvar gi;
  generate
    for (gi = 0; gi < etp_pkg::ETP_PIN_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= pins_raw[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate
  assign pins_s = sync_r;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [1:0] tsel_r;
  logic slave_r;
  logic [15:0] frames_r;
  logic wr_en;
  logic loop_mode;
  assign wr_en = psel & penable & pwrite;
  assign loop_mode = (tsel_r == etp_pkg::ETP_TSEL_LOOP);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tsel_r <= etp_pkg::ETP_TSEL_RST;
      slave_r <= etp_pkg::ETP_SLAVE_RST;
    end else if (wr_en && paddr == etp_pkg::ETP_CTRL_OFS) begin
      tsel_r <= pwdata[etp_pkg::ETP_CTRL_TSEL_LSB +: 2];
      slave_r <= pwdata[etp_pkg::ETP_CTRL_SLAVE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  logic ref_s;
  logic ref_d_r;
  logic tick;
  // local clock is not looked at at all while loop timed
  assign ref_s = loop_mode ? pins_s.line_clk : pins_s.local_clk;
  assign tick = ref_s & ~ref_d_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_d_r <= 1'b0;
    end else begin
      ref_d_r <= ref_s;
    end
  end

  // line clock copied out to the terminal only while loop timed
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      loop_timed_clock_out <= 1'b0;
    end else begin
      loop_timed_clock_out <= loop_mode & pins_s.line_clk;
    end
  end

  // ----------------------------------------------------------------
  // frame reference (slave mode)
  // ----------------------------------------------------------------
  logic fref_d_r;
  logic fref_rise;
  logic restart_r;
  logic restart_nxt;
  assign fref_rise = slave_r & ~loop_mode & pins_s.frame_ref & ~fref_d_r;
  // a new edge in the consuming cycle keeps the request alive
  assign restart_nxt = fref_rise | (restart_r & ~tick);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fref_d_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      fref_d_r <= pins_s.frame_ref;
      restart_r <= restart_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bit counter, warning and end of frame
  // ----------------------------------------------------------------
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic next_is_oh;
  logic cur_is_oh;
  assign cnt_nxt = (restart_r || cnt_r == LAST) ? etp_pkg::ETP_CNT_RST :
                   cnt_r + 1'b1;
  assign cur_is_oh = (cnt_nxt < OHN);
  // the bit after a frame's last one is always overhead
  assign next_is_oh = (cnt_nxt == LAST) || ((cnt_nxt + 1'b1) < OHN);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= LAST;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_overhead_warning <= 1'b0;
      tx_end_of_frame_pulse <= 1'b0;
    end else if (tick) begin
      tx_overhead_warning <= next_is_oh;
      tx_end_of_frame_pulse <= (cnt_nxt == LAST);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frames_r <= etp_pkg::ETP_FRMS_RST;
    end else if (tick && cnt_nxt == LAST) begin
      frames_r <= frames_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // nibble clock
  // ----------------------------------------------------------------
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  logic nib_take;
  logic pay_tick;
  assign pay_tick = tick & ~cur_is_oh;
  assign phase_nxt = phase_r + 2'h1;
  assign nib_take = pay_tick & pins_s.nib_sel & (phase_nxt == 2'h0);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase_r <= etp_pkg::ETP_PHASE_RST;
      tx_nibble_sample_clock <= 1'b0;
    end else if (!pins_s.nib_sel) begin
      phase_r <= etp_pkg::ETP_PHASE_RST;
      tx_nibble_sample_clock <= 1'b0;
    end else if (pay_tick) begin
      phase_r <= phase_nxt;
      // high for two payload bits, low for two; rises on each take
      tx_nibble_sample_clock <= ~phase_nxt[1];
    end
  end

  // ----------------------------------------------------------------
  // payload capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      payload_out <= '0;
    end else if (nib_take) begin
      payload_out <= '{valid: 1'b1, nibble: 1'b1,
                       data: pins_s.nibble};
    end else if (pay_tick && !pins_s.nib_sel) begin
      // overhead slots never reach here, the pin is ignored then
      payload_out <= '{valid: 1'b1, nibble: 1'b0,
                       data: {3'h0, pins_s.serial}};
    end else begin
      payload_out.valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb read side
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      etp_pkg::ETP_CTRL_OFS: begin
        rd_mux[etp_pkg::ETP_CTRL_TSEL_LSB +: 2] = tsel_r;
        rd_mux[etp_pkg::ETP_CTRL_SLAVE_BIT] = slave_r;
      end
      etp_pkg::ETP_STAT_OFS: begin
        rd_mux[CW-1:0] = cnt_r;
        rd_mux[etp_pkg::ETP_STAT_NIB_BIT] = pins_s.nib_sel;
        rd_mux[etp_pkg::ETP_STAT_LOOP_BIT] = loop_mode;
      end
      etp_pkg::ETP_FRMS_OFS: begin
        rd_mux[15:0] = frames_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rd_hit;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end
endmodule

// ### dv/etp_tx_payload_in_sva.sv
`timescale 1ns/100ps
module etp_tx_payload_in_sva #(
  parameter int FRAME_BITS = 16,
  parameter int OH_BITS = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic nibble_interface_select,
  input wire logic line_recovered_clock,
  input wire logic tx_nibble_sample_clock,
  input wire logic tx_overhead_warning,
  input wire logic tx_end_of_frame_pulse,
  input wire logic loop_timed_clock_out,
  input wire etp_pkg::etp_payload_s payload_out
);
  // ----------------------------------------------------------------
  // timing select shadow, kept from bus writes
  // ----------------------------------------------------------------
  logic [1:0] tsel_r;
  logic loop_sel;
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      tsel_r <= etp_pkg::ETP_TSEL_RST;
    else if (psel && penable && pwrite && paddr == etp_pkg::ETP_CTRL_OFS)
      tsel_r <= pwdata[etp_pkg::ETP_CTRL_TSEL_LSB +: 2];
  end
  assign loop_sel = tsel_r == etp_pkg::ETP_TSEL_LOOP;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_APB_READY: assert property (psel && penable |-> pready)
    else $error("no ready");
  AST_UNMAPPED_ERR: assert property (
    psel && penable && paddr > etp_pkg::ETP_FRMS_OFS |-> pslverr)
    else $error("unmapped not refused");
  AST_LOOP_CLK_OFF: assert property (
    !loop_sel [*4] |-> !loop_timed_clock_out) else $error("loop clk");
  AST_LOOP_CLK_FOLLOW: assert property (
    loop_sel && $rose(line_recovered_clock)
    |-> ##[1:4] (loop_timed_clock_out || !loop_sel))
    else $error("loop clk missing");
  AST_NIBCLK_SERIAL: assert property (
    !nibble_interface_select [*6] |-> !tx_nibble_sample_clock)
    else $error("nibble clk in serial");
  AST_EOF_WARN: assert property (
    OH_BITS > 0 && FRAME_BITS > OH_BITS && tx_end_of_frame_pulse
    |-> tx_overhead_warning) else $error("no warning at eof");
  AST_EOF_WIDTH: assert property (
    $rose(tx_end_of_frame_pulse) |-> tx_end_of_frame_pulse [*5]
    ##[1:15] !tx_end_of_frame_pulse) else $error("eof width");
  AST_OH_NO_DATA: assert property (
    $fell(tx_overhead_warning) |-> !payload_out.valid)
    else $error("overhead bit taken");
  AST_ONE_SAMPLE: assert property (
    payload_out.valid |=> !payload_out.valid) else $error("valid width");
  cover property ($rose(tx_end_of_frame_pulse));
  cover property (payload_out.valid && payload_out.nibble);
  cover property (psel && penable && pslverr);
endmodule
bind etp_tx_payload_in etp_tx_payload_in_sva #(.FRAME_BITS(FRAME_BITS),
  .OH_BITS(OH_BITS)) etp_tx_payload_in_sva_i (.clk_sys, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .nibble_interface_select, .line_recovered_clock, .tx_nibble_sample_clock,
  .tx_overhead_warning, .tx_end_of_frame_pulse, .loop_timed_clock_out,
  .payload_out);

// ### dv/etp_terminal_model.sv
`timescale 1ns/100ps
module etp_terminal_model #(
  parameter int HALF_NS = 240
) (
  output logic ref_clk,
  input wire logic warning,
  input wire logic loop_clk,
  input wire logic loop_sel,
  output logic serial,
  output logic [3:0] nibble
);
  wire sel_clk = loop_sel ? loop_clk : ref_clk;
  initial begin
    ref_clk = 1'b0;
    serial = 1'b0;
    nibble = 4'h5;
    #13;
    forever #(HALF_NS) ref_clk = ~ref_clk;
  end
  // update on the fall so data is steady around the sampling rise;
  // overhead slots carry junk 0, payload resumes after them
  always @(negedge sel_clk) begin
    serial <= !warning;
  end
endmodule

// ### dv/etp_tx_payload_in_test.sv
`timescale 1ns/100ps
module etp_tx_payload_in_test;
  localparam int FB = 16;
  localparam int NS = FB - 4;
  localparam int LP = 560;
  localparam int TP = 480;
  typedef struct {logic [1:0] ts; logic nb; int per; int nv;} etp_row_s;
  etp_row_s rows[5] = '{'{2'h0, 1'b0, LP, NS}, '{2'h1, 1'b0, TP, NS},
    '{2'h2, 1'b1, TP, NS / 4}, '{2'h0, 1'b1, LP, NS / 4},
    '{2'h3, 1'b0, TP, NS}};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, loop_sel, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic tx_serial_payload_in, nibble_interface_select, tx_local_ref_clock;
  logic line_recovered_clock, tx_frame_reference_in, tx_nibble_sample_clock;
  logic tx_overhead_warning, tx_end_of_frame_pulse, loop_timed_clock_out;
  logic [3:0] tx_nibble_payload_in;
  etp_pkg::etp_payload_s payload_out;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_eof = 0;
  int nv, k;
  int n_nck = 0;
  realtime t0, t1;
  always #20 clk_sys = ~clk_sys;
  always @(posedge tx_end_of_frame_pulse) n_eof++;
  always @(posedge tx_nibble_sample_clock) n_nck++;
  initial begin
    line_recovered_clock = 1'b0;
    #7;
    forever #(LP / 2) line_recovered_clock = ~line_recovered_clock;
  end
  etp_tx_payload_in #(.FRAME_BITS(FB), .OH_BITS(4)) etp_tx_payload_in_i (.*);
  etp_terminal_model #(.HALF_NS(TP / 2)) etp_terminal_model_i (
    .ref_clk(tx_local_ref_clock), .warning(tx_overhead_warning),
    .loop_clk(loop_timed_clock_out), .loop_sel(loop_sel),
    .serial(tx_serial_payload_in), .nibble(tx_nibble_payload_in));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // polls to the next end-of-frame rise, counting payload samples
  task automatic frame(input logic on, nb, output int n, output realtime t);
    logic pe;
    pe = 1'b1;
    n = 0;
    while (1'b1) begin
      @(posedge clk_sys);
      if (payload_out.valid === 1'b1) begin
        n++;
        if (on) chk("data", nb ? 32'({1'b1, payload_out.data}) : 32'({
          payload_out.nibble, payload_out.data[0]}), nb ? 32'h15 : 32'h1);
      end
      if (tx_end_of_frame_pulse === 1'b1 && pe === 1'b0) break;
      pe = tx_end_of_frame_pulse;
    end
    t = $realtime;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {psel, penable, pwrite, nibble_interface_select} = 4'h0;
    {tx_frame_reference_in, loop_sel, paddr, pwdata} = {2'b01, 44'h0};
    repeat (12) @(posedge clk_sys);
    chk("reset outs", 32'({tx_overhead_warning, tx_end_of_frame_pulse,
      tx_nibble_sample_clock, loop_timed_clock_out, payload_out}), 32'h0);
    sys_rst <= 1'b0;
    apb(1'b0, etp_pkg::ETP_STAT_OFS, 32'h0, d, e);
    chk("status", 32'(d[14:13]), 32'h2);
    foreach (rows[i]) begin
      apb(1'b1, etp_pkg::ETP_CTRL_OFS, 32'(rows[i].ts), d, e);
      nibble_interface_select <= rows[i].nb;
      loop_sel <= rows[i].ts == etp_pkg::ETP_TSEL_LOOP;
      repeat (2) frame(1'b0, rows[i].nb, nv, t0);
      k = n_nck;
      frame(1'b1, rows[i].nb, nv, t1);
      chk("count", 32'(nv), 32'(rows[i].nv));
      chk("nibble clk", 32'(n_nck - k),
        rows[i].nb ? 32'(rows[i].nv) : 32'h0);
      chk("frame time", 32'(t1 - t0 > rows[i].per * FB - 100 && t1 - t0 <
        rows[i].per * FB + 100), 32'h1);
    end
    // frame reference rise well inside a frame
    apb(1'b1, etp_pkg::ETP_CTRL_OFS, 32'h5, d, e);
    repeat (2) frame(1'b0, 1'b0, nv, t0);
    repeat (36) @(posedge clk_sys);
    tx_frame_reference_in <= 1'b1;
    t0 = $realtime;
    repeat (30) @(posedge clk_sys);
    tx_frame_reference_in <= 1'b0;
    frame(1'b1, 1'b0, nv, t1);
    chk("restart", 32'(t1 - t0 > 15 * TP && t1 - t0 < 16 * TP + 240), 32'h1);
    apb(1'b0, etp_pkg::ETP_FRMS_OFS, 32'h0, d, e);
    chk("frames", d, 32'(n_eof[15:0]));
    apb(1'b1, 12'h00c, 32'h0, d, e);
    chk("unmapped", 32'(e), 32'h1);
    apb(1'b0, etp_pkg::ETP_CTRL_OFS, 32'h0, d, e);
    chk("ctrl", d, 32'h5);
    print_verdict();
  end
endmodule
